// *** core/xbad_consts.svh ***
`ifndef XBAD_CONSTS_SVH
`define XBAD_CONSTS_SVH

`define XBAD_AW            24
`define XBAD_PEN_W         16
`define XBAD_SYS_W         16
// system config and peripheral enable bit positions
`define XBAD_SYS_GPEN_BIT  2
`define XBAD_PEN_CAN1_BIT  0
`define XBAD_PEN_CAN2_BIT  1
`define XBAD_PEN_RAM1_BIT  2
`define XBAD_PEN_RAM2_BIT  3
`define XBAD_PEN_RTC_BIT   4
`define XBAD_PEN_PWM_BIT   6
`define XBAD_PEN_ASC_BIT   7
`define XBAD_PEN_SSC_BIT   8
`define XBAD_PEN_I2C_BIT   9
`define XBAD_PEN_MISC_BIT  10
// internal flash map
`define XBAD_FL_LO_BASE    24'h000000
`define XBAD_FL_LO_END     24'h007fff
`define XBAD_FL_HI_BASE    24'h018000
`define XBAD_FL_HI_END     24'h04ffff
`define XBAD_TF_END        24'h000fff
// ext ram areas
`define XBAD_RAM1_BASE     24'h00e000
`define XBAD_RAM1_END      24'h00e7ff
`define XBAD_RAM2_RST_BASE 24'h090000
`define XBAD_RAM2_MASK     24'hffc000
`define XBAD_RAM2_RST_LIM  24'h0fffff
// peripheral pages, upper 16 address bits
`define XBAD_PG_SSC        16'h00e8
`define XBAD_PG_ASC        16'h00e9
`define XBAD_PG_I2C        16'h00ea
`define XBAD_PG_MISC       16'h00eb
`define XBAD_PG_PWM        16'h00ec
`define XBAD_PG_RTC        16'h00ed
`define XBAD_PG_CAN2       16'h00ee
`define XBAD_PG_CAN1       16'h00ef
// special register areas, 2 x 512 bytes
`define XBAD_SFR_BASE      24'h00fe00
`define XBAD_SFR_END       24'h00ffff
`define XBAD_ESFR_BASE     24'h00f000
`define XBAD_ESFR_END      24'h00f1ff
// access timing
`define XBAD_CPU_MHZ       40
`define XBAD_PERIPH_NS     100
`define XBAD_RAM_NS        50
`define XBAD_PERIPH_WAIT   2'h2
`define XBAD_RAM_WAIT      2'h0
`define XBAD_SEG_LINES_CAN 4'h4
`define XBAD_SEG_LINES_ALL 4'h8

`endif

// *** core/xbad_pkg.sv ***
package xbad_pkg;
   typedef enum logic [13:0] {
      XBAD_T_EXT   = 14'h0001,
      XBAD_T_FLASH = 14'h0002,
      XBAD_T_TFL   = 14'h0004,
      XBAD_T_RAM1  = 14'h0008,
      XBAD_T_RAM2  = 14'h0010,
      XBAD_T_SFR   = 14'h0020,
      XBAD_T_CAN1  = 14'h0040,
      XBAD_T_CAN2  = 14'h0080,
      XBAD_T_RTC   = 14'h0100,
      XBAD_T_PWM   = 14'h0200,
      XBAD_T_ASC   = 14'h0400,
      XBAD_T_SSC   = 14'h0800,
      XBAD_T_I2C   = 14'h1000,
      XBAD_T_MISC  = 14'h2000
   } xbad_target_t;
endpackage

// *** core/xbad_page_match.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "xbad_consts.svh"
// one 256-byte peripheral page, claimed only when fully enabled
module xbad_page_match #(
   parameter logic [15:0] PAGE = 16'h0000
) (
   input  wire logic [23:0] addr,     // cpu address
   input  wire logic        gen,      // global enable
   input  wire logic        pen,      // peripheral enable
   output logic             hit       // page claimed
);
   assign hit = gen && pen && (addr[23:8] == PAGE);
endmodule
`default_nettype wire

// *** core/xbad_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "xbad_consts.svh"
// Functional notes
// - one 16 Mbyte space, byte or word
// - user flash blocks at documented addresses
// - test flash hidden, at zero in boot
// - ram one decoded when both enables set
// - ram two at programmed window base
// - global enable clear sends ram two external
// - ram two reset window mirrored to 0fffff
// - ram demultiplexed, zero waits, byte or word
// - ram not stack, registers, or bits
// - two 512-byte special register areas
// - can one page with enable bit 0
// - can two page with enable bit 1
// - rtc page with enable bit 4
// - extra pwm page with enable bit 6
// - async serial two with bit 7
// - sync serial two with bit 8
// - i2c bit 9, misc bit 10
// - peripherals word only, demultiplexed, 16-bit
// - peripherals two waits, no tristate wait
// - can in use limits segment lines
// - disabled peripheral occupies nothing
// - clocks gated after init, no reset; misc and ram clocks stay enabled
module xbad_decoder
   import xbad_pkg::*;
(
   input  wire logic                     clk,           // 125 MHz clock
   input  wire logic                     rst,           // sync reset
   input  wire logic                     acc_valid,     // cpu access
   input  wire logic [23:0]              acc_addr,      // byte address
   input  wire logic                     acc_byte,      // byte access
   input  wire logic                     acc_write,     // write access
   input  wire logic                     boot_mode,     // bootstrap mode
   input  wire logic [15:0]              system_config_reg, // sys config
   input  wire logic [15:0]              periph_enable_reg, // enables
   input  wire logic                     win_wr,        // load window
   input  wire logic [23:0]              win_base,      // ram two base
   input  wire logic [23:0]              win_limit,     // mirror limit
   input  wire logic                     end_of_init_instr, // init done
   output xbad_pkg::xbad_target_t        sel_r,         // chosen target
   output logic                          sel_valid_r,   // sel qualifier
   output logic [23:0]                   sel_addr_r,    // forwarded addr
   output logic                          sel_write_r,   // forwarded dir
   output logic                          sel_byte_r,    // forwarded size
   output logic                          demux_r,       // demux addr
   output logic [1:0]                    wait_r,        // wait states
   output logic                          tristate_wait_r, // always low
   output logic                          access_err_r,  // byte refused
   output logic                          bit_addr_ok_r, // bit ops ok
   output logic                          stack_ok_r,    // stack allowed
   output logic [3:0]                    seg_lines_r,   // segment lines
   output logic [10:0]                   periph_clk_en_r, // clock gates
   output logic [23:0]                   ram_two_window_reg // window
);
   import xbad_pkg::*;

   logic [23:0]   win_base_r;
   logic [23:0]   win_lim_r;
   logic          init_done_r;
   xbad_target_t  sel_nxt;
   wire           gen = system_config_reg[`XBAD_SYS_GPEN_BIT];
   wire [15:0]    pen = periph_enable_reg;

   // programmable ram two window, reset to mirrored area
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         win_base_r <= `XBAD_RAM2_RST_BASE;
         win_lim_r  <= `XBAD_RAM2_RST_LIM;
      end
      else if (win_wr)
      begin
         win_base_r <= win_base & `XBAD_RAM2_MASK;
         win_lim_r  <= win_limit;
      end
   end

   wire a_lo_fl = acc_addr <= `XBAD_FL_LO_END;
   wire a_hi_fl = (acc_addr >= `XBAD_FL_HI_BASE)
                  && (acc_addr <= `XBAD_FL_HI_END);
   // boot hides low user flash behind test flash
   wire hit_tfl   = boot_mode && (acc_addr <= `XBAD_TF_END);
   wire hit_flash = (a_lo_fl && !boot_mode) || a_hi_fl;
   wire hit_ram1  = gen && pen[`XBAD_PEN_RAM1_BIT]
                    && (acc_addr >= `XBAD_RAM1_BASE)
                    && (acc_addr <= `XBAD_RAM1_END);
   // mirrored: any 16K block from base up to limit
   wire hit_ram2  = gen && pen[`XBAD_PEN_RAM2_BIT]
                    && (acc_addr >= win_base_r)
                    && (acc_addr <= win_lim_r);
   wire hit_sfr   = ((acc_addr >= `XBAD_SFR_BASE)
                     && (acc_addr <= `XBAD_SFR_END))
                    || ((acc_addr >= `XBAD_ESFR_BASE)
                     && (acc_addr <= `XBAD_ESFR_END));

   wire [7:0] pg_hit;
   localparam logic [15:0] PAGES [8] = '{`XBAD_PG_CAN1, `XBAD_PG_CAN2,
      `XBAD_PG_RTC, `XBAD_PG_PWM, `XBAD_PG_ASC, `XBAD_PG_SSC,
      `XBAD_PG_I2C, `XBAD_PG_MISC};
   wire [7:0] pg_en = {pen[`XBAD_PEN_MISC_BIT], pen[`XBAD_PEN_I2C_BIT],
      pen[`XBAD_PEN_SSC_BIT], pen[`XBAD_PEN_ASC_BIT],
      pen[`XBAD_PEN_PWM_BIT], pen[`XBAD_PEN_RTC_BIT],
      pen[`XBAD_PEN_CAN2_BIT], pen[`XBAD_PEN_CAN1_BIT]};

   // disabled pages simply fail to match
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_pg
         xbad_page_match #(.PAGE(PAGES[g])) u_pm (
            .addr (acc_addr),
            .gen  (gen),
            .pen  (pg_en[g]),
            .hit  (pg_hit[g])
         );
      end
   endgenerate

   wire hit_periph = |pg_hit;

   // priority chain guarantees exactly one target
   always_comb
   begin
      sel_nxt = XBAD_T_EXT;
      if (hit_tfl)
         sel_nxt = XBAD_T_TFL;
      else if (hit_flash)
         sel_nxt = XBAD_T_FLASH;
      else if (pg_hit[0])
         sel_nxt = XBAD_T_CAN1;
      else if (pg_hit[1])
         sel_nxt = XBAD_T_CAN2;
      else if (pg_hit[2])
         sel_nxt = XBAD_T_RTC;
      else if (pg_hit[3])
         sel_nxt = XBAD_T_PWM;
      else if (pg_hit[4])
         sel_nxt = XBAD_T_ASC;
      else if (pg_hit[5])
         sel_nxt = XBAD_T_SSC;
      else if (pg_hit[6])
         sel_nxt = XBAD_T_I2C;
      else if (pg_hit[7])
         sel_nxt = XBAD_T_MISC;
      else if (hit_ram1)
         sel_nxt = XBAD_T_RAM1;
      else if (hit_ram2)
         sel_nxt = XBAD_T_RAM2;
      else if (hit_sfr)
         sel_nxt = XBAD_T_SFR;
   end

   wire is_ram = hit_ram1 || hit_ram2;
   wire periph_now = hit_periph && !hit_tfl && !hit_flash;
   wire ram_now = is_ram && !hit_periph && !hit_tfl && !hit_flash;
   // byte access to a word-only peripheral is refused
   wire byte_err = acc_valid && periph_now && acc_byte;
   wire [1:0] wait_nxt = periph_now ? `XBAD_PERIPH_WAIT
                                    : `XBAD_RAM_WAIT;
   wire can_used = gen && (pen[`XBAD_PEN_CAN1_BIT]
                           || pen[`XBAD_PEN_CAN2_BIT]);
   wire [10:0] clk_keep = {1'b1, pen[9:4], 2'b11, pen[1:0]};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sel_r           <= XBAD_T_EXT;
         sel_valid_r     <= 1'b0;
         sel_addr_r      <= 24'h000000;
         sel_write_r     <= 1'b0;
         sel_byte_r      <= 1'b0;
         demux_r         <= 1'b0;
         wait_r          <= 2'h0;
         tristate_wait_r <= 1'b0;
         access_err_r    <= 1'b0;
         bit_addr_ok_r   <= 1'b0;
         stack_ok_r      <= 1'b0;
         seg_lines_r     <= `XBAD_SEG_LINES_ALL;
         init_done_r     <= 1'b0;
         periph_clk_en_r <= 11'h7ff;
      end
      else
      begin
         sel_r           <= sel_nxt;
         sel_valid_r     <= acc_valid && !byte_err;
         sel_addr_r      <= acc_addr;
         sel_write_r     <= acc_write;
         sel_byte_r      <= acc_byte;
         demux_r         <= periph_now || ram_now;
         wait_r          <= wait_nxt;
         tristate_wait_r <= 1'b0;
         access_err_r    <= byte_err;
         // ram behaves like external memory: no bits, no stack
         bit_addr_ok_r   <= hit_sfr && !periph_now && !ram_now;
         stack_ok_r      <= 1'b0;
         seg_lines_r     <= can_used ? `XBAD_SEG_LINES_CAN
                                     : `XBAD_SEG_LINES_ALL;
         init_done_r     <= init_done_r || end_of_init_instr;
         // gating only, never a reset to the peripheral
         if (init_done_r || end_of_init_instr)
            periph_clk_en_r <= clk_keep;
      end
   end

   assign ram_two_window_reg = win_base_r;
endmodule
`default_nettype wire

// *** test/xbad_periph_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far-side page target: keeps the waits it served and any byte access
module xbad_periph_model
   import xbad_pkg::*;
(
   input  wire logic                   clk,         // clock
   input  wire logic                   rst,         // sync reset
   input  wire logic                   sel_valid_r, // access strobe
   input  wire logic                   sel_byte_r,  // byte size
   input  wire xbad_pkg::xbad_target_t sel_r,       // target
   input  wire logic [1:0]             wait_r,      // waits granted
   output logic [1:0]                  served_r,    // last page waits
   output logic                        byte_seen_r  // word-only broken
);
   wire logic is_page = (sel_r >= XBAD_T_CAN1);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         served_r    <= 2'h0;
         byte_seen_r <= 1'b0;
      end
      else if (sel_valid_r && is_page)
      begin
         served_r    <= wait_r;
         byte_seen_r <= byte_seen_r | sel_byte_r;
      end
   end
endmodule
`default_nettype wire

// *** test/xbad_decoder_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module xbad_decoder_assertions
   import xbad_pkg::*;
(
   input  wire logic        clk, rst, acc_valid, acc_byte, boot_mode, // cpu
   input  wire logic [23:0] acc_addr,                           // address
   input  wire logic [15:0] system_config_reg, periph_enable_reg, // enables
   input  wire xbad_pkg::xbad_target_t sel_r,                   // target
   input  wire logic        sel_valid_r, demux_r, tristate_wait_r, // flags
   input  wire logic        access_err_r, stack_ok_r,           // attributes
   input  wire logic [1:0]  wait_r,                             // waits
   input  wire logic [3:0]  seg_lines_r                         // seg lines
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic        gen = system_config_reg[2];
   wire logic [15:0] pg  = acc_addr[23:8];
   wire logic        r1  = acc_valid && acc_addr[23:11] == 13'h001c;
   sequence s_can1_req;
      acc_valid && pg == 16'h00ef && gen && periph_enable_reg[0];
   endsequence
   sequence s_page_answer;
      sel_valid_r && sel_r == XBAD_T_CAN1 ##0 wait_r == 2'h2 && demux_r;
   endsequence
   chk_can1_page:
      assert property (s_can1_req ##0 !acc_byte |=> s_page_answer)
      else $error("can one page not served");
   chk_byte_refused:
      assert property (s_can1_req ##0 acc_byte |=> access_err_r && !sel_valid_r)
      else $error("byte access to page not refused");
   chk_ram_one_on:
      assert property (r1 && gen && periph_enable_reg[2]
                       |=> sel_r == XBAD_T_RAM1 && wait_r == 2'h0)
      else $error("ram one not selected");
   chk_ram_one_off:
      assert property (r1 && !(gen && periph_enable_reg[2])
                       |=> sel_r == XBAD_T_EXT)
      else $error("disabled ram one not external");
   chk_rtc_hidden:
      assert property (acc_valid && pg == 16'h00ed && !periph_enable_reg[4]
                       |=> sel_r == XBAD_T_EXT)
      else $error("disabled page still claimed");
   chk_user_flash:
      assert property (acc_valid && !boot_mode && acc_addr <= 24'h007fff
                       |=> sel_r == XBAD_T_FLASH)
      else $error("low flash not selected");
   chk_boot_test:
      assert property (acc_valid && boot_mode && acc_addr <= 24'h000fff
                       |=> sel_r == XBAD_T_TFL)
      else $error("test flash not at zero");
   chk_seg_four:
      assert property (gen && periph_enable_reg[1:0] != 2'h0
                       |=> seg_lines_r == 4'h4)
      else $error("segment lines not limited");
   chk_no_tristate:
      assert property (!tristate_wait_r && !stack_ok_r)
      else $error("tristate wait or stack allowed");
endmodule
bind xbad_decoder xbad_decoder_assertions i_xbad_decoder_assertions (.clk,
   .rst, .acc_valid, .acc_byte, .boot_mode, .acc_addr, .system_config_reg,
   .periph_enable_reg, .sel_r, .sel_valid_r, .demux_r, .tristate_wait_r,
   .access_err_r, .stack_ok_r, .wait_r, .seg_lines_r);
`default_nettype wire

// *** test/xbad_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module xbad_decoder_tb;
   import xbad_pkg::*;
   typedef struct {logic [23:0] a; bit b, bt; logic [15:0] s, p;
                   xbad_target_t t;} xbad_row_t;
   localparam logic [15:0] G = 16'h0004;
   logic clk = 0, rst = 1, acc_valid = 0, acc_byte = 0, acc_write = 0;
   logic boot_mode = 0, win_wr = 0, end_of_init_instr = 0;
   logic [23:0] acc_addr = '0, win_base = '0, win_limit = '0;
   logic [15:0] system_config_reg = '0, periph_enable_reg = '0;
   xbad_target_t sel_r;
   logic sel_valid_r, sel_byte_r, demux_r, tristate_wait_r, access_err_r;
   logic bit_addr_ok_r, stack_ok_r, byte_seen_r;
   logic [1:0] wait_r, served_r;
   logic [3:0] seg_lines_r;
   logic [10:0] periph_clk_en_r;
   logic [23:0] ram_two_window_reg;
   int failures = 0, tests_run = 0, cyc = 0;
   xbad_row_t rows [$] = '{
      '{24'h000100, 0, 0, G, 0, XBAD_T_FLASH},
      '{24'h018001, 1, 0, G, 0, XBAD_T_FLASH},
      '{24'h04ffff, 0, 0, G, 0, XBAD_T_FLASH},
      '{24'h008000, 0, 0, G, 0, XBAD_T_EXT},
      '{24'h000ffe, 0, 1, G, 0, XBAD_T_TFL},
      '{24'h00e000, 1, 0, G, 4, XBAD_T_RAM1},
      '{24'h00e7ff, 0, 0, 0, 4, XBAD_T_EXT},
      '{24'h00e000, 0, 0, G, 0, XBAD_T_EXT},
      '{24'h090000, 0, 0, G, 8, XBAD_T_RAM2},
      '{24'h0fc003, 1, 0, G, 8, XBAD_T_RAM2},
      '{24'h093fff, 0, 0, 0, 8, XBAD_T_EXT},
      '{24'h00fe00, 0, 0, G, 0, XBAD_T_SFR},
      '{24'h00f1fe, 0, 0, G, 0, XBAD_T_SFR},
      '{24'h00ef00, 0, 0, G, 16'h0001, XBAD_T_CAN1},
      '{24'h00eeff, 0, 0, G, 16'h0002, XBAD_T_CAN2},
      '{24'h00ed10, 0, 0, G, 16'h0010, XBAD_T_RTC},
      '{24'h00ec00, 0, 0, G, 16'h0040, XBAD_T_PWM},
      '{24'h00e9fe, 0, 0, G, 16'h0080, XBAD_T_ASC},
      '{24'h00e800, 0, 0, G, 16'h0100, XBAD_T_SSC},
      '{24'h00ea00, 0, 0, G, 16'h0200, XBAD_T_I2C},
      '{24'h00eb00, 0, 0, G, 16'h0400, XBAD_T_MISC},
      '{24'h00ed00, 0, 0, G, 16'h07ef, XBAD_T_EXT},
      '{24'h00ef00, 0, 0, 0, 16'hffff, XBAD_T_EXT},
      '{24'h00ea01, 1, 0, G, 16'h0200, XBAD_T_I2C}};
   xbad_decoder i_xbad_decoder (.clk, .rst, .acc_valid, .acc_addr, .acc_byte,
      .acc_write, .boot_mode, .system_config_reg, .periph_enable_reg, .win_wr,
      .win_base, .win_limit, .end_of_init_instr, .sel_r, .sel_valid_r,
      .sel_addr_r(), .sel_write_r(), .sel_byte_r, .demux_r, .wait_r,
      .tristate_wait_r, .access_err_r, .bit_addr_ok_r, .stack_ok_r,
      .seg_lines_r, .periph_clk_en_r, .ram_two_window_reg);
   xbad_periph_model i_xbad_periph_model (.clk, .rst, .sel_valid_r,
      .sel_byte_r, .sel_r, .wait_r, .served_r, .byte_seen_r);
   task automatic tally_and_finish;
      $display("counts: tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(bit ok, string m);
      tests_run++;
      if (!ok)
      begin
         failures++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // drive at a falling edge, look one full cycle later
   task automatic access(xbad_row_t r);
      bit pg, er;
      pg = (r.t >= XBAD_T_CAN1);
      er = pg && r.b;
      {acc_valid, acc_addr, acc_byte, boot_mode} = {1'b1, r.a, r.b, r.bt};
      {system_config_reg, periph_enable_reg} = {r.s, r.p};
      acc_write = ~acc_write;
      @(negedge clk);
      check(sel_valid_r === !er && access_err_r === er, "refusal");
      if (!er) check(sel_r === r.t, "target");
      // page decode sets the waits even when a byte access is refused
      check(wait_r === (pg ? 2'h2 : 2'h0), "waits");
      if (pg && !er) check(demux_r === 1'b1, "demux");
      check(seg_lines_r === (r.s[2] && r.p[1:0] != 0 ? 4'h4 : 4'h8),
            "segment lines");
      if (r.t inside {XBAD_T_RAM1, XBAD_T_RAM2})
         check(bit_addr_ok_r === 1'b0, "ram bit ops");
   endtask
   task automatic reset_vals;
      check(sel_r === XBAD_T_EXT && sel_valid_r === 1'b0, "rst sel");
      check(periph_clk_en_r === 11'h7ff, "rst gates");
      check(ram_two_window_reg === 24'h090000, "rst window");
      $display("test reset done");
   endtask
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 500)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (4) @(negedge clk);
      reset_vals();
      rst = 0;
      foreach (rows[i]) access(rows[i]);
      check(served_r === 2'h2 && byte_seen_r === 1'b0, "far side");
      $display("test table done");
      {win_wr, win_base, win_limit} = {1'b1, 24'h0a4000, 24'h0a7fff};
      @(negedge clk);
      win_wr = 0;
      check(ram_two_window_reg === 24'h0a4000, "window");
      access('{24'h0a5ffe, 0, 0, G, 8, XBAD_T_RAM2});
      access('{24'h090000, 0, 0, G, 8, XBAD_T_EXT});
      periph_enable_reg = 16'h0001;
      end_of_init_instr = 1;
      @(negedge clk);
      end_of_init_instr = 0;
      @(negedge clk);
      check(periph_clk_en_r === 11'h40d, "gating");
      $display("test window and gating done");
      rst = 1;
      repeat (2) @(negedge clk);
      reset_vals();
      rst = 0;
      access(rows[0]);
      tally_and_finish();
   end
endmodule
`default_nettype wire
